// ### swing_consts.vh
`ifndef SWING_CONSTS_VH
`define SWING_CONSTS_VH

// ----------------------------------------
// widths and defaults
// ----------------------------------------
`define SW_TMR_W     16
`define SW_CUR_W     16
`define SW_Z_W       16
`define SW_ANG_W     9
`define SW_ANG_RIGHT 9'h05a
`define SW_NUM_TMR   5

// ----------------------------------------
// timer slots
// ----------------------------------------
`define SW_T_PKP1    0
`define SW_T_RST1    1
`define SW_T_PKP2    2
`define SW_T_PKP3    3
`define SW_T_PKP4    4

`endif

// ### sw_delay_timer.v
`default_nettype none
`include "swing_consts.vh"

module sw_delay_timer #(
	parameter TW = `SW_TMR_W
) (
	input  wire          clk_i,
	input  wire          sys_rst_i,
	input  wire          run_i,
	input  wire [TW-1:0] limit_i,
	output wire          done_o
);
	reg [TW-1:0] cnt_q;

	// expiry seen the cycle the elapsed count reaches the limit
	assign done_o = run_i & (cnt_q >= limit_i);

	always @(posedge clk_i) begin
		if (sys_rst_i) begin
			cnt_q <= {TW{1'b0}};
		end else if (!run_i) begin
			cnt_q <= {TW{1'b0}};
		end else if (cnt_q != {TW{1'b1}}) begin
			cnt_q <= cnt_q + {{(TW-1){1'b0}}, 1'b1};
		end
	end
endmodule // sw_delay_timer
`default_nettype wire

// ### sw_trip_hold.v
`default_nettype none
`include "swing_consts.vh"

module sw_trip_hold #(
	parameter TW = `SW_TMR_W
) (
	input  wire          clk_i,
	input  wire          sys_rst_i,
	input  wire          raw_i,
	input  wire [TW-1:0] hold_i,
	output wire          hold_o
);
	reg [TW-1:0] left_q;

	// raw event plus hold-1 further cycles, never shorter than one
	assign hold_o = raw_i | (left_q > {{(TW-1){1'b0}}, 1'b1});

	always @(posedge clk_i) begin
		if (sys_rst_i) begin
			left_q <= {TW{1'b0}};
		end else if (raw_i) begin
			left_q <= hold_i;
		end else if (left_q != {TW{1'b0}}) begin
			left_q <= left_q - {{(TW-1){1'b0}}, 1'b1};
		end
	end
endmodule // sw_trip_hold
`default_nettype wire

// ### swing_sequencer.v
`default_nettype none
`include "swing_consts.vh"

module swing_sequencer #(
	parameter TW = `SW_TMR_W,
	parameter CW = `SW_CUR_W,
	parameter ZW = `SW_Z_W,
	parameter AW = `SW_ANG_W
) (
	input  wire            clk_i,
	input  wire            sys_rst_i,
	input  wire            enable_i,
	input  wire            mode_3step_i,
	input  wire            shape_quad_i,
	input  wire            trip_delayed_i,
	input  wire            oos_inhibit_in_i,
	input  wire            disturbance_detect_in_i,
	input  wire [CW-1:0]   pos_seq_current_i,
	input  wire [CW-1:0]   overcurrent_supervision_level_i,
	input  wire            outer_raw_i,
	input  wire            middle_raw_i,
	input  wire            inner_raw_i,
	input  wire [TW-1:0]   pickup1_i,
	input  wire [TW-1:0]   reset1_i,
	input  wire [TW-1:0]   pickup2_i,
	input  wire [TW-1:0]   pickup3_i,
	input  wire [TW-1:0]   pickup4_i,
	input  wire [TW-1:0]   trip_hold_time_i,
	input  wire [ZW-1:0]   fwd_reach_i,
	input  wire [ZW-1:0]   rev_reach_i,
	input  wire [ZW-1:0]   quad_fwd_mid_i,
	input  wire [ZW-1:0]   quad_fwd_out_i,
	input  wire [ZW-1:0]   quad_rev_mid_i,
	input  wire [ZW-1:0]   quad_rev_out_i,
	input  wire [AW-1:0]   forward_char_angle_i,
	input  wire [AW-1:0]   reverse_char_angle_i,
	input  wire [AW-1:0]   outer_limit_angle_i,
	input  wire [AW-1:0]   middle_limit_angle_i,
	input  wire [AW-1:0]   inner_limit_angle_i,
	input  wire [3*ZW-1:0] left_blinder_reach_i,
	input  wire [3*ZW-1:0] right_blinder_reach_i,
	output reg             swing_block_o,
	output reg             swing_block_fault_release_out_o,
	output reg             trip_o,
	output reg             outer_o,
	output reg             middle_o,
	output reg             inner_o,
	output reg             tmr2_pkp_o,
	output reg             tmr3_pkp_o,
	output reg             tmr4_pkp_o,
	output reg             incoming_o,
	output reg             outgoing_o,
	output reg [3*ZW-1:0]  zone_fwd_reach_o,
	output reg [3*ZW-1:0]  zone_rev_reach_o,
	output reg [AW-1:0]    zone_fwd_angle_o,
	output reg [AW-1:0]    zone_rev_angle_o,
	output reg [3*ZW-1:0]  zone_right_bound_o,
	output reg [3*ZW+2:0]  zone_left_bound_o,
	output reg [2:0]       zone_apple_o,
	output reg             middle_angle_used_o,
	output reg [3*AW-1:0]  zone_limit_angle_o
);
	// ----------------------------------------
	// zone qualification
	// ----------------------------------------
	wire oc_ok;
	wire z_out;
	wire z_mid;
	wire z_in;
	wire band1;

	// upstream flags already carry shape, reach and blinders
	// below the supervision level nothing counts as entered
	assign oc_ok = pos_seq_current_i >= overcurrent_supervision_level_i;
	assign z_out = enable_i & oc_ok & outer_raw_i;
	assign z_mid = enable_i & oc_ok & mode_3step_i & middle_raw_i;
	assign z_in  = enable_i & oc_ok & inner_raw_i;

	// first band: outer minus middle, or outer minus inner in 2-step
	assign band1 = z_out & ~(mode_3step_i ? z_mid : z_in);

	// ----------------------------------------
	// sequence state
	// ----------------------------------------
	reg  step1_q;
	reg  step2_q;
	reg  step3_q;
	reg  step4_q;
	reg  dd_seen_q;
	wire step2_eff;
	wire [`SW_NUM_TMR-1:0]    tmr_run;
	wire [`SW_NUM_TMR-1:0]    tmr_done;
	wire [`SW_NUM_TMR*TW-1:0] tmr_lim;

	// 2-step passes straight from the first step to the inner stage
	assign step2_eff = mode_3step_i ? step2_q : step1_q;

	assign tmr_run[`SW_T_PKP1] = band1;
	assign tmr_run[`SW_T_RST1] = swing_block_o & ~z_out;
	assign tmr_run[`SW_T_PKP2] = mode_3step_i & step1_q & ~step2_q & z_mid & ~z_in;
	assign tmr_run[`SW_T_PKP3] = step2_eff & ~step3_q & z_in;
	assign tmr_run[`SW_T_PKP4] = trip_delayed_i & step3_q & ~step4_q
		& z_out & ~z_in;

	assign tmr_lim = {pickup4_i, pickup3_i, pickup2_i, reset1_i, pickup1_i};

	// ----------------------------------------
	// timers
	// ----------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < `SW_NUM_TMR; gi = gi + 1) begin : g_tmr
			sw_delay_timer #(
				.TW (TW)
			) u_tmr (
				.clk_i     (clk_i),
				.sys_rst_i (sys_rst_i),
				.run_i     (tmr_run[gi]),
				.limit_i   (tmr_lim[gi*TW +: TW]),
				.done_o    (tmr_done[gi])
			);
		end
	endgenerate

	// ----------------------------------------
	// trip event and seal-in
	// ----------------------------------------
	wire raw_early;
	wire raw_delayed;
	wire raw_trip;
	wire trip_held;

	// early: same edge that sets the final step also sets the trip
	assign raw_early   = ~trip_delayed_i & tmr_done[`SW_T_PKP3];
	// delayed: armed locus dropping out of the outer zone, one cycle
	assign raw_delayed = enable_i & trip_delayed_i & step4_q & ~z_out;
	assign raw_trip    = raw_early | raw_delayed;

	// a new raw event while sealed reloads the full hold time
	sw_trip_hold #(
		.TW (TW)
	) u_hold (
		.clk_i     (clk_i),
		.sys_rst_i (sys_rst_i),
		.raw_i     (raw_trip),
		.hold_i    (trip_hold_time_i),
		.hold_o    (trip_held)
	);

	// ----------------------------------------
	// blocking and tripping latches
	// ----------------------------------------
	reg block_d;

	// pickup expiry wins over a reset-timer expiry in the same cycle
	always @* begin
		block_d = swing_block_o;
		if (!enable_i) begin
			block_d = 1'b0;
		end else if (tmr_done[`SW_T_PKP1]) begin
			block_d = 1'b1;
		end else if (tmr_done[`SW_T_RST1]) begin
			block_d = 1'b0;
		end
	end

	always @(posedge clk_i) begin
		if (sys_rst_i) begin
			swing_block_o                   <= 1'b0;
			swing_block_fault_release_out_o <= 1'b0;
			dd_seen_q                       <= 1'b0;
			step1_q                         <= 1'b0;
			step2_q                         <= 1'b0;
			step3_q                         <= 1'b0;
			step4_q                         <= 1'b0;
			trip_o                          <= 1'b0;
			incoming_o                      <= 1'b0;
			outgoing_o                      <= 1'b0;
		end else begin
			swing_block_o <= block_d;
			// disturbance during an established swing drops release until swing ends
			if (!block_d) begin
				dd_seen_q <= 1'b0;
			end else if (swing_block_o & disturbance_detect_in_i) begin
				dd_seen_q <= 1'b1;
			end
			swing_block_fault_release_out_o <= block_d & ~dd_seen_q
				& ~(swing_block_o & disturbance_detect_in_i);

			// steps survive only while inside the outer zone
			if (!z_out) begin
				step1_q <= 1'b0;
				step2_q <= 1'b0;
				step3_q <= 1'b0;
				step4_q <= 1'b0;
			end else begin
				if (tmr_done[`SW_T_PKP1]) begin
					step1_q <= 1'b1;
				end
				if (tmr_done[`SW_T_PKP2]) begin
					step2_q <= 1'b1;
				end
				if (tmr_done[`SW_T_PKP3]) begin
					step3_q <= 1'b1;
				end
				if (tmr_done[`SW_T_PKP4]) begin
					step4_q <= 1'b1;
				end
			end

			// inhibit masks only the output; the sequence keeps running
			trip_o     <= enable_i & ~oos_inhibit_in_i & trip_held;
			incoming_o <= tmr_done[`SW_T_PKP3];
			outgoing_o <= enable_i & step3_q & ~z_out;
		end
	end

	// ----------------------------------------
	// auxiliary flags
	// ----------------------------------------
	always @(posedge clk_i) begin
		if (sys_rst_i) begin
			outer_o    <= 1'b0;
			middle_o   <= 1'b0;
			inner_o    <= 1'b0;
			tmr2_pkp_o <= 1'b0;
			tmr3_pkp_o <= 1'b0;
			tmr4_pkp_o <= 1'b0;
		end else begin
			outer_o    <= z_out;
			middle_o   <= z_mid;
			inner_o    <= z_in;
			tmr2_pkp_o <= tmr_run[`SW_T_PKP2];
			tmr3_pkp_o <= tmr_run[`SW_T_PKP3];
			tmr4_pkp_o <= tmr_run[`SW_T_PKP4];
		end
	end

	// ----------------------------------------
	// characteristic configuration for the comparator
	// ----------------------------------------
	// zone order in packed buses: [0] inner, [1] middle, [2] outer
	wire [3*ZW-1:0] fwd_d;
	wire [3*ZW-1:0] rev_d;
	wire [2:0]      apple_d;

	// mho uses one reach for all; quad keeps own mid/outer reaches
	assign fwd_d = shape_quad_i
		? {quad_fwd_out_i, quad_fwd_mid_i, fwd_reach_i}
		: {fwd_reach_i, fwd_reach_i, fwd_reach_i};
	assign rev_d = shape_quad_i
		? {quad_rev_out_i, quad_rev_mid_i, rev_reach_i}
		: {rev_reach_i, rev_reach_i, rev_reach_i};

	// apple only meaningful for mho; quad zones report lens
	assign apple_d[0] = ~shape_quad_i & (inner_limit_angle_i > `SW_ANG_RIGHT);
	assign apple_d[1] = ~shape_quad_i & mode_3step_i
		& (middle_limit_angle_i > `SW_ANG_RIGHT);
	assign apple_d[2] = ~shape_quad_i & (outer_limit_angle_i > `SW_ANG_RIGHT);

	// ----------------------------------------
	// left blinder sign
	// ----------------------------------------
	// entered as a magnitude; the comparator wants a negative resistive bound
	wire [3*ZW+2:0] left_neg;
	genvar          gz;

	generate
		for (gz = 0; gz < 3; gz = gz + 1) begin : g_left
			// extra sign bit keeps the full magnitude range representable
			assign left_neg[gz*(ZW+1) +: ZW+1] =
				{1'b1, ~left_blinder_reach_i[gz*ZW +: ZW]} + {{ZW{1'b0}}, 1'b1};
		end
	endgenerate

	always @(posedge clk_i) begin
		if (sys_rst_i) begin
			zone_fwd_reach_o    <= {(3*ZW){1'b0}};
			zone_rev_reach_o    <= {(3*ZW){1'b0}};
			zone_fwd_angle_o    <= {AW{1'b0}};
			zone_rev_angle_o    <= {AW{1'b0}};
			zone_right_bound_o  <= {(3*ZW){1'b0}};
			zone_left_bound_o   <= {(3*ZW+3){1'b0}};
			zone_apple_o        <= 3'h0;
			middle_angle_used_o <= 1'b0;
			zone_limit_angle_o  <= {(3*AW){1'b0}};
		end else begin
			zone_fwd_reach_o   <= fwd_d;
			zone_rev_reach_o   <= rev_d;
			// forward angle also sets blinders and both quad reach angles
			zone_fwd_angle_o   <= forward_char_angle_i;
			zone_rev_angle_o   <= shape_quad_i ? forward_char_angle_i
				: reverse_char_angle_i;
			zone_right_bound_o <= right_blinder_reach_i;
			zone_left_bound_o   <= left_neg;
			zone_apple_o        <= apple_d;
			middle_angle_used_o <= mode_3step_i & ~shape_quad_i;
			zone_limit_angle_o  <= {outer_limit_angle_i,
				(mode_3step_i ? middle_limit_angle_i : {AW{1'b0}}),
				inner_limit_angle_i};
		end
	end
endmodule // swing_sequencer
`default_nettype wire

// ### zone_source_model.sv
`default_nettype none
// ----
// upstream zone comparator
// ----
module zone_source_model (
	input  wire logic [1:0] pos_i,
	output wire logic       outer_o,
	output wire logic       middle_o,
	output wire logic       inner_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// nested zones: inner implies middle implies outer
	assign outer_o  = pos_i != 2'h0;
	assign middle_o = pos_i[1];
	assign inner_o  = pos_i == 2'h3;
endmodule // zone_source_model
`default_nettype wire

// ### swing_sequencer_checker.sv
`default_nettype none
// ----
// checker
// ----
module swing_sequencer_checker (
	input wire logic        clk_i,
	input wire logic        sys_rst_i,
	input wire logic        enable_i,
	input wire logic        mode_3step_i,
	input wire logic        trip_delayed_i,
	input wire logic        oos_inhibit_in_i,
	input wire logic        disturbance_detect_in_i,
	input wire logic [15:0] pos_seq_current_i,
	input wire logic [15:0] overcurrent_supervision_level_i,
	input wire logic        outer_raw_i,
	input wire logic [15:0] trip_hold_time_i,
	input wire logic        swing_block_o,
	input wire logic        swing_block_fault_release_out_o,
	input wire logic        trip_o,
	input wire logic        outer_o,
	input wire logic        middle_o,
	input wire logic        incoming_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (sys_rst_i);
	wire logic q_out;
	assign q_out = enable_i && outer_raw_i
		&& (pos_seq_current_i >= overcurrent_supervision_level_i);
	// three cycles inside, so a stale reset-timer expiry cannot count
	sequence s_inside;
		q_out [*3];
	endsequence
	sequence s_seal;
		trip_o [*4] ##1 !trip_o;
	endsequence
	AST_ZONE: assert property (!$past(sys_rst_i) |-> outer_o == $past(q_out))
		else $error("outer flag not qualified");
	AST_MID2: assert property (!$past(sys_rst_i) && !$past(mode_3step_i) |-> !middle_o)
		else $error("middle flag in 2-step");
	AST_INH: assert property ($past(oos_inhibit_in_i) |-> !trip_o)
		else $error("trip while inhibited");
	AST_DIST: assert property (swing_block_o && disturbance_detect_in_i |=>
		!swing_block_fault_release_out_o) else $error("release kept on disturbance");
	AST_REL: assert property (swing_block_fault_release_out_o |-> swing_block_o)
		else $error("release without block");
	AST_BHOLD: assert property (s_inside ##0 swing_block_o |=> swing_block_o)
		else $error("block dropped inside outer");
	AST_EARLY: assert property ($rose(incoming_o) && !$past(trip_delayed_i) &&
		!$past(oos_inhibit_in_i) |-> trip_o) else $error("early trip late");
	AST_SEAL: assert property ($rose(trip_o) && trip_delayed_i && !oos_inhibit_in_i &&
		trip_hold_time_i == 16'h0004 |-> s_seal) else $error("seal-in length wrong");
	AST_DLY: assert property ($rose(trip_o) && $past(trip_delayed_i) |-> !outer_o)
		else $error("delayed trip inside outer");
endmodule // swing_sequencer_checker
bind swing_sequencer swing_sequencer_checker chk_u (
	.clk_i(clk_i), .sys_rst_i(sys_rst_i), .enable_i(enable_i), .mode_3step_i(mode_3step_i),
	.trip_delayed_i(trip_delayed_i), .oos_inhibit_in_i(oos_inhibit_in_i),
	.disturbance_detect_in_i(disturbance_detect_in_i),
	.pos_seq_current_i(pos_seq_current_i),
	.overcurrent_supervision_level_i(overcurrent_supervision_level_i),
	.outer_raw_i(outer_raw_i), .trip_hold_time_i(trip_hold_time_i),
	.swing_block_o(swing_block_o),
	.swing_block_fault_release_out_o(swing_block_fault_release_out_o),
	.trip_o(trip_o), .outer_o(outer_o), .middle_o(middle_o), .incoming_o(incoming_o)
);
`default_nettype wire

// ### swing_sequencer_tb_top.sv
`default_nettype none
// ----
// bench
// ----
module swing_sequencer_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk_i, sys_rst_i, enable_i, mode_3step_i, shape_quad_i;
	logic        trip_delayed_i, oos_inhibit_in_i, disturbance_detect_in_i;
	logic [15:0] pos_seq_current_i, overcurrent_supervision_level_i, trip_hold_time_i;
	logic [15:0] pickup1_i, reset1_i, pickup2_i, pickup3_i, pickup4_i;
	logic [15:0] fwd_reach_i, rev_reach_i, quad_fwd_mid_i, quad_fwd_out_i;
	logic [15:0] quad_rev_mid_i, quad_rev_out_i;
	logic [8:0]  forward_char_angle_i, reverse_char_angle_i;
	logic [8:0]  outer_limit_angle_i, middle_limit_angle_i, inner_limit_angle_i;
	logic [47:0] left_blinder_reach_i, right_blinder_reach_i;
	wire         outer_raw_i, middle_raw_i, inner_raw_i, swing_block_o, trip_o;
	wire         swing_block_fault_release_out_o, incoming_o, outgoing_o;
	wire         outer_o, middle_o, inner_o, tmr2_pkp_o, tmr3_pkp_o, tmr4_pkp_o;
	wire         middle_angle_used_o;
	wire [47:0]  zone_fwd_reach_o, zone_rev_reach_o, zone_right_bound_o;
	wire [8:0]   zone_fwd_angle_o, zone_rev_angle_o;
	wire [50:0]  zone_left_bound_o;
	wire [2:0]   zone_apple_o;
	wire [26:0]  zone_limit_angle_o;
	logic [1:0]  pos;
	int          num_errors, checks_done, cyc;
	zone_source_model src (.pos_i(pos), .outer_o(outer_raw_i), .middle_o(middle_raw_i),
		.inner_o(inner_raw_i));
	swing_sequencer dut (
		.clk_i(clk_i), .sys_rst_i(sys_rst_i), .enable_i(enable_i),
		.mode_3step_i(mode_3step_i), .shape_quad_i(shape_quad_i),
		.trip_delayed_i(trip_delayed_i), .oos_inhibit_in_i(oos_inhibit_in_i),
		.disturbance_detect_in_i(disturbance_detect_in_i),
		.pos_seq_current_i(pos_seq_current_i),
		.overcurrent_supervision_level_i(overcurrent_supervision_level_i),
		.outer_raw_i(outer_raw_i), .middle_raw_i(middle_raw_i), .inner_raw_i(inner_raw_i),
		.pickup1_i(pickup1_i), .reset1_i(reset1_i), .pickup2_i(pickup2_i),
		.pickup3_i(pickup3_i), .pickup4_i(pickup4_i), .trip_hold_time_i(trip_hold_time_i),
		.fwd_reach_i(fwd_reach_i), .rev_reach_i(rev_reach_i),
		.quad_fwd_mid_i(quad_fwd_mid_i), .quad_fwd_out_i(quad_fwd_out_i),
		.quad_rev_mid_i(quad_rev_mid_i), .quad_rev_out_i(quad_rev_out_i),
		.forward_char_angle_i(forward_char_angle_i),
		.reverse_char_angle_i(reverse_char_angle_i),
		.outer_limit_angle_i(outer_limit_angle_i),
		.middle_limit_angle_i(middle_limit_angle_i),
		.inner_limit_angle_i(inner_limit_angle_i),
		.left_blinder_reach_i(left_blinder_reach_i),
		.right_blinder_reach_i(right_blinder_reach_i),
		.swing_block_o(swing_block_o),
		.swing_block_fault_release_out_o(swing_block_fault_release_out_o),
		.trip_o(trip_o), .outer_o(outer_o), .middle_o(middle_o), .inner_o(inner_o),
		.tmr2_pkp_o(tmr2_pkp_o), .tmr3_pkp_o(tmr3_pkp_o), .tmr4_pkp_o(tmr4_pkp_o),
		.incoming_o(incoming_o), .outgoing_o(outgoing_o),
		.zone_fwd_reach_o(zone_fwd_reach_o), .zone_rev_reach_o(zone_rev_reach_o),
		.zone_fwd_angle_o(zone_fwd_angle_o), .zone_rev_angle_o(zone_rev_angle_o),
		.zone_right_bound_o(zone_right_bound_o), .zone_left_bound_o(zone_left_bound_o),
		.zone_apple_o(zone_apple_o), .middle_angle_used_o(middle_angle_used_o),
		.zone_limit_angle_o(zone_limit_angle_o)
	);
	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end
	// hang guard, well beyond the few hundred cycles the tests need
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			num_errors = num_errors + 1;
			wrap_up();
		end
	end
	task chk(input logic [63:0] seen, input logic [63:0] exp);
		checks_done = checks_done + 1;
		if (seen !== exp) begin
			num_errors = num_errors + 1;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task go(input logic [1:0] p, input int n);
		pos = p;
		repeat (n) @(negedge clk_i);
	endtask
	task to_inner();
		go(2'h1, 8);
		go(2'h2, 8);
		go(2'h3, 8);
	endtask
	task wrap_up();
		if (num_errors == 0 && checks_done > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	initial begin
		num_errors = 0;
		checks_done = 0;
		cyc = 0;
		pos = 2'h0;
		sys_rst_i = 1'b1;
		enable_i = 1'b1;
		mode_3step_i = 1'b1;
		shape_quad_i = 1'b0;
		trip_delayed_i = 1'b0;
		oos_inhibit_in_i = 1'b0;
		disturbance_detect_in_i = 1'b0;
		pos_seq_current_i = 16'h0100;
		overcurrent_supervision_level_i = 16'h0080;
		pickup1_i = 16'h0003;
		reset1_i = 16'h0004;
		pickup2_i = 16'h0003;
		pickup3_i = 16'h0003;
		pickup4_i = 16'h0003;
		trip_hold_time_i = 16'h0004;
		fwd_reach_i = 16'h0200;
		rev_reach_i = 16'h0100;
		quad_fwd_mid_i = 16'h0300;
		quad_fwd_out_i = 16'h0400;
		quad_rev_mid_i = 16'h0180;
		quad_rev_out_i = 16'h0240;
		forward_char_angle_i = 9'h050;
		reverse_char_angle_i = 9'h046;
		outer_limit_angle_i = 9'h078;
		middle_limit_angle_i = 9'h064;
		inner_limit_angle_i = 9'h050;
		left_blinder_reach_i = 48'h0300_0200_0100;
		right_blinder_reach_i = 48'h0300_0200_0100;
		repeat (16) @(negedge clk_i);
		sys_rst_i = 1'b0;
		go(2'h1, 2);
		chk(swing_block_o, 1'b0);
		chk(zone_fwd_reach_o, 48'h0200_0200_0200);
		chk(zone_rev_reach_o, 48'h0100_0100_0100);
		chk(zone_fwd_angle_o, 9'h050);
		chk(zone_rev_angle_o, 9'h046);
		chk(zone_right_bound_o, 48'h0300_0200_0100);
		chk(zone_left_bound_o[16:0], 17'h1ff00);
		chk(zone_left_bound_o[33:17], 17'h1fe00);
		chk(zone_left_bound_o[50:34], 17'h1fd00);
		chk(zone_apple_o, 3'h6);
		chk(middle_angle_used_o, 1'b1);
		chk(zone_limit_angle_o, 27'h1e0c850);
		go(2'h1, 6);
		chk(swing_block_o, 1'b1);
		chk(swing_block_fault_release_out_o, 1'b1);
		disturbance_detect_in_i = 1'b1;
		go(2'h2, 2);
		chk(swing_block_fault_release_out_o, 1'b0);
		chk(middle_o, 1'b1);
		chk(tmr2_pkp_o, 1'b1);
		disturbance_detect_in_i = 1'b0;
		go(2'h2, 6);
		go(2'h3, 1);
		chk(trip_o, 1'b0);
		chk(inner_o, 1'b1);
		chk(tmr3_pkp_o, 1'b1);
		go(2'h3, 2);
		chk(trip_o, 1'b0);
		go(2'h3, 1);
		chk(trip_o, 1'b1);
		chk(incoming_o, 1'b1);
		go(2'h3, 2);
		chk(trip_o, 1'b1);
		go(2'h3, 8);
		chk(trip_o, 1'b0);
		go(2'h0, 2);
		chk(swing_block_o, 1'b1);
		go(2'h0, 8);
		chk(swing_block_o, 1'b0);
		go(2'h1, 8);
		go(2'h3, 10);
		chk(trip_o, 1'b0);
		go(2'h0, 12);
		// 2-step: middle flag must not interrupt the first band
		mode_3step_i = 1'b0;
		go(2'h1, 2);
		chk(middle_angle_used_o, 1'b0);
		chk(zone_limit_angle_o[17:9], 9'h000);
		chk(zone_apple_o, 3'h4);
		go(2'h2, 6);
		chk(swing_block_o, 1'b1);
		chk(middle_o, 1'b0);
		chk(tmr2_pkp_o, 1'b0);
		go(2'h3, 6);
		chk(trip_o, 1'b1);
		go(2'h0, 12);
		mode_3step_i = 1'b1;
		pos_seq_current_i = 16'h007f;
		go(2'h1, 8);
		chk(outer_o, 1'b0);
		chk(swing_block_o, 1'b0);
		pos_seq_current_i = 16'h0080;
		go(2'h1, 8);
		chk(swing_block_o, 1'b1);
		go(2'h0, 12);
		trip_delayed_i = 1'b1;
		to_inner();
		chk(trip_o, 1'b0);
		go(2'h2, 1);
		go(2'h0, 10);
		chk(trip_o, 1'b0);
		to_inner();
		go(2'h2, 2);
		chk(tmr4_pkp_o, 1'b1);
		go(2'h2, 6);
		go(2'h0, 1);
		chk(outgoing_o, 1'b1);
		go(2'h0, 3);
		chk(trip_o, 1'b1);
		chk(outgoing_o, 1'b0);
		go(2'h0, 8);
		chk(trip_o, 1'b0);
		trip_delayed_i = 1'b0;
		trip_hold_time_i = 16'h0010;
		oos_inhibit_in_i = 1'b1;
		go(2'h1, 8);
		chk(swing_block_o, 1'b1);
		go(2'h2, 8);
		go(2'h3, 8);
		chk(trip_o, 1'b0);
		oos_inhibit_in_i = 1'b0;
		go(2'h3, 2);
		chk(trip_o, 1'b1);
		go(2'h0, 12);
		// quad shape: own mid/outer reaches, forward angle everywhere, no apple
		shape_quad_i = 1'b1;
		go(2'h1, 8);
		chk(zone_fwd_reach_o, 48'h0400_0300_0200);
		chk(zone_rev_reach_o, 48'h0240_0180_0100);
		chk(zone_rev_angle_o, 9'h050);
		chk(zone_apple_o, 3'h0);
		chk(middle_angle_used_o, 1'b0);
		chk(swing_block_o, 1'b1);
		enable_i = 1'b0;
		go(2'h1, 2);
		chk(swing_block_o, 1'b0);
		chk(outer_o, 1'b0);
		enable_i = 1'b1;
		go(2'h0, 4);
		wrap_up();
	end
endmodule // swing_sequencer_tb_top
`default_nettype wire
